// >>> guard_pkg.sv
/*
 package for the boot section access guard: register map, field positions,
 reset values and shared structs. assumes a 32-bit classic wishbone slave.
*/
package guard_pkg;
   localparam logic [7:0] OFF_LOCK = 8'h00;
   localparam logic [7:0] OFF_FUSE = 8'h04;
   localparam logic [7:0] OFF_CMD = 8'h08;
   localparam logic [7:0] OFF_POINTER = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_RDATA = 8'h14;
   localparam logic [7:0] OFF_WADDR = 8'h18;
   localparam int LOCK_BOOT_HIGH_POS = 3;
   localparam int LOCK_BOOT_LOW_POS = 2;
   localparam int LOCK_APP_HIGH_POS = 1;
   localparam int LOCK_APP_LOW_POS = 0;
   localparam logic [3:0] LOCK_RESET = 4'hF;
   localparam logic BOOT_RESET_FUSE_RESET = 1'b1;
   localparam int CMD_WRITE_POS = 0;
   localparam int CMD_READ_POS = 1;
   localparam int CMD_LOCK_POS = 2;
   localparam int CMD_FROM_BOOT_POS = 3;
   localparam int CMD_IVEC_BOOT_POS = 4;
   localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

   typedef struct packed
   {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } wb_req_type;

   typedef struct packed
   {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_type;

   typedef struct packed
   {
      logic write_ok;
      logic read_ok;
   } verdict_type;
endpackage

// >>> section_check.sv
/*
 one section's lock decode: write and read permission for an access.
 assumes the caller says whether target and executing code are in this section.
*/
`timescale 1ns/100ps
module section_check
   import guard_pkg::*;
(
   input wire logic lock_high, // lock field upper bit, 0 = programmed
   input wire logic lock_low, // lock field lower bit, 0 = programmed
   input wire logic target_here, // access targets this section
   input wire logic code_elsewhere, // code runs from the other section
   output verdict_type verdict // permissions for this access
);
   always_comb
   begin
      verdict.write_ok = 1'b1;
      verdict.read_ok = 1'b1;
      if (target_here)
      begin
         if (!lock_low)
         begin
            verdict.write_ok = 1'b0;
         end
         if (!lock_high && code_elsewhere)
         begin
            verdict.read_ok = 1'b0;
         end
      end
   end
endmodule

// >>> boot_section_access_guard.sv
/*
 boot section access guard: lock fields, reset vector selection, pointer
 address latching and permission checks for self-programming writes and
 program memory reads. assumes a classic wishbone master, one clock domain,
 and a core that presents commands through the command register.
 assumes BOOT_START is a word address on a page boundary and that the
 flash answers a read word within the cycle after the read command.
*/
`timescale 1ns/100ps
module boot_section_access_guard
   import guard_pkg::*;
#(
   parameter int PAGE_WORD_BITS = 7,
   parameter logic [15:0] BOOT_START = 16'h7000
)
(
   input wire logic CLK_SYS, // system clock, 50 MHz
   input wire logic ARST_N, // asynchronous reset, active low
   input wire logic WB_CYC_I, // wishbone cycle
   input wire logic WB_STB_I, // wishbone strobe
   input wire logic WB_WE_I, // wishbone write enable
   input wire logic [3:0] WB_SEL_I, // wishbone byte selects
   input wire logic [7:0] WB_ADR_I, // wishbone byte address
   input wire logic [31:0] WB_DAT_I, // wishbone write data
   input wire logic CHIP_ERASE, // programming interface chip erase pulse
   input wire logic FUSE_LOAD, // programming interface fuse load pulse
   input wire logic FUSE_VALUE, // boot reset fuse value to load
   input wire logic [15:0] FLASH_RDATA, // word read from flash
   output logic WB_ACK_O, // wishbone acknowledge
   output logic [31:0] WB_DAT_O, // wishbone read data
   output logic FLASH_WE, // flash write strobe, one cycle
   output logic [15:0] FLASH_WADDR, // latched word address for write
   output logic [15:0] FLASH_RADDR, // word address for read
   output logic IRQ_MASK, // interrupt mask to the core
   output logic [15:0] RESET_VECTOR // fetch address after reset
);
   typedef struct packed
   {
      logic ack;
      logic [31:0] rdat;
      logic [3:0] lock;
      logic fuse;
      logic [15:0] pointer;
      logic [15:0] waddr;
      logic we;
      logic [15:0] raddr;
      logic read_pending;
      logic read_byte_sel;
      logic [7:0] read_byte;
      logic from_boot;
      logic ivec_boot;
      logic irq_mask;
      logic [15:0] vector;
      logic write_rejected;
      logic read_rejected;
      logic write_done;
      logic spm_refused;
   } state_type;

   state_type s_q;
   state_type s_d;
   verdict_type app_v;
   verdict_type boot_v;
   logic target_boot;
   logic access;
   logic [31:0] wdat;
   logic [15:0] ptr_word;
   logic [15:0] page_number_field;
   logic [15:0] word_in_page_field;
   logic write_allowed;
   logic read_allowed;

   // a page needs one word bit at least and leaves one page bit at least
   if (PAGE_WORD_BITS < 1 || PAGE_WORD_BITS > 14)
   begin : g_page_bits_check
      $error("PAGE_WORD_BITS out of range");
   end

   // pointer word addresses stop at 16'h7FFF; the boundary must sit on a page
   if (BOOT_START == 16'h0000 || BOOT_START[15] || (BOOT_START % (1 << PAGE_WORD_BITS)) != 0)
   begin : g_boot_start_check
      $error("BOOT_START not a reachable page boundary");
   end

   // the pointer holds a byte address; bit zero only picks a byte on reads
   assign ptr_word = {1'b0, s_q.pointer[15:1]};

   // during a read the latched address is checked, the live pointer otherwise
   always_comb
   begin
      if (s_q.read_pending)
      begin
         target_boot = (s_q.raddr >= BOOT_START);
      end
      else
      begin
         target_boot = (ptr_word >= BOOT_START);
      end
   end

   always_comb
   begin
      word_in_page_field = s_q.waddr & 16'((1 << PAGE_WORD_BITS) - 1);
      page_number_field = s_q.waddr >> PAGE_WORD_BITS;
   end

   section_check u_app
   (
      .lock_high(s_q.lock[LOCK_APP_HIGH_POS]),
      .lock_low(s_q.lock[LOCK_APP_LOW_POS]),
      .target_here(!target_boot),
      .code_elsewhere(s_q.from_boot),
      .verdict(app_v)
   );

   section_check u_boot
   (
      .lock_high(s_q.lock[LOCK_BOOT_HIGH_POS]),
      .lock_low(s_q.lock[LOCK_BOOT_LOW_POS]),
      .target_here(target_boot),
      .code_elsewhere(!s_q.from_boot),
      .verdict(boot_v)
   );

   // the section not targeted always grants, so only the target's verdict counts
   always_comb
   begin
      if (ptr_word >= BOOT_START)
      begin
         write_allowed = boot_v.write_ok;
      end
      else
      begin
         write_allowed = app_v.write_ok;
      end
      // both verdicts come from the section lock fields and where code runs
      read_allowed = app_v.read_ok && boot_v.read_ok;
   end

   // ack high blocks a second take, so each request gets exactly one ack
   assign access = WB_CYC_I && WB_STB_I && !s_q.ack;

   always_comb
   begin
      wdat = s_q.rdat;
      wdat[7:0] = WB_SEL_I[0] ? WB_DAT_I[7:0] : 8'h00;
      wdat[15:8] = WB_SEL_I[1] ? WB_DAT_I[15:8] : 8'h00;
      wdat[23:16] = WB_SEL_I[2] ? WB_DAT_I[23:16] : 8'h00;
      wdat[31:24] = WB_SEL_I[3] ? WB_DAT_I[31:24] : 8'h00;
   end

   always_comb
   begin
      s_d = s_q;
      s_d.ack = access;
      s_d.we = 1'b0;
      s_d.read_pending = 1'b0;
      // general lock modes play no part in either verdict
      if (s_q.read_pending)
      begin
         if (read_allowed)
         begin
            s_d.read_byte = s_q.read_byte_sel ? FLASH_RDATA[15:8] : FLASH_RDATA[7:0];
            s_d.read_rejected = 1'b0;
         end
         else
         begin
            s_d.read_byte = 8'h00;
            s_d.read_rejected = 1'b1;
         end
      end
      if (FUSE_LOAD)
      begin
         s_d.fuse = FUSE_VALUE;
      end
      // masked only while code runs away from the section that holds the vectors
      s_d.irq_mask = 1'b0;
      if (s_q.ivec_boot && !s_q.from_boot && !s_q.lock[LOCK_APP_HIGH_POS])
      begin
         s_d.irq_mask = 1'b1;
      end
      if (!s_q.ivec_boot && s_q.from_boot && !s_q.lock[LOCK_BOOT_HIGH_POS])
      begin
         s_d.irq_mask = 1'b1;
      end
      if (s_q.fuse)
      begin
         s_d.vector = APP_RESET_ADDR;
      end
      else
      begin
         s_d.vector = BOOT_START;
      end
      if (access)
      begin
         s_d.rdat = 32'h0000_0000;
         if (WB_WE_I)
         begin
            case (WB_ADR_I)
               OFF_LOCK:
               begin
                  // only 1 to 0: programming, never erasing
                  s_d.lock = s_q.lock & wdat[3:0];
               end
               OFF_CMD:
               begin
                  // each command also reports where code runs and where vectors sit
                  s_d.from_boot = wdat[CMD_FROM_BOOT_POS];
                  s_d.ivec_boot = wdat[CMD_IVEC_BOOT_POS];
                  if (wdat[CMD_WRITE_POS])
                  begin
                     if (!wdat[CMD_FROM_BOOT_POS])
                     begin
                        s_d.spm_refused = 1'b1;
                     end
                     else
                     begin
                        s_d.spm_refused = 1'b0;
                        s_d.waddr = ptr_word;
                        // judged on the very word address that is latched
                        if (write_allowed)
                        begin
                           s_d.we = 1'b1;
                           s_d.write_rejected = 1'b0;
                        end
                        else
                        begin
                           s_d.write_rejected = 1'b1;
                        end
                        s_d.write_done = 1'b1;
                     end
                  end
                  if (wdat[CMD_READ_POS])
                  begin
                     s_d.raddr = ptr_word;
                     s_d.read_byte_sel = s_q.pointer[0];
                     s_d.read_pending = 1'b1;
                  end
                  if (wdat[CMD_LOCK_POS])
                  begin
                     s_d.lock = s_q.lock & wdat[7:4];
                  end
               end
               OFF_POINTER:
               begin
                  s_d.pointer = wdat[15:0];
               end
               default:
               begin
                  s_d.fuse = s_q.fuse;
               end
            endcase
         end
         else
         begin
            case (WB_ADR_I)
               OFF_LOCK:
               begin
                  s_d.rdat = {28'h000_0000, s_q.lock};
               end
               OFF_FUSE:
               begin
                  s_d.rdat = {31'h0000_0000, s_q.fuse};
               end
               OFF_POINTER:
               begin
                  s_d.rdat = {16'h0000, s_q.pointer};
               end
               OFF_STATUS:
               begin
                  s_d.rdat = {28'h000_0000, s_q.spm_refused, s_q.write_done,
                     s_q.read_rejected, s_q.write_rejected};
               end
               OFF_RDATA:
               begin
                  s_d.rdat = {24'h00_0000, s_q.read_byte};
               end
               OFF_WADDR:
               begin
                  // page number above the word-in-page bits
                  s_d.rdat = {16'h0000, (page_number_field << PAGE_WORD_BITS)
                     | word_in_page_field};
               end
               default:
               begin
                  s_d.rdat = 32'h0000_0000;
               end
            endcase
         end
      end
      // erase from the programming interface wins over a lock write in the same cycle
      if (CHIP_ERASE)
      begin
         s_d.lock = LOCK_RESET;
      end
   end

   // locks and fuse come up unprogrammed, so fetch starts at the application
   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         s_q <= '0;
         s_q.lock <= LOCK_RESET;
         s_q.fuse <= BOOT_RESET_FUSE_RESET;
         s_q.vector <= APP_RESET_ADDR;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // every output is a bit of the registered state
   assign WB_ACK_O = s_q.ack;
   assign WB_DAT_O = s_q.rdat;
   assign FLASH_WE = s_q.we;
   assign FLASH_WADDR = s_q.waddr;
   assign FLASH_RADDR = s_q.raddr;
   assign IRQ_MASK = s_q.irq_mask;
   assign RESET_VECTOR = s_q.vector;
endmodule

// >>> guard_assertions.sv
/*
 port-level checker for the boot section access guard.
 assumes the one-cycle wishbone answer and registered outputs of the note.
*/
`timescale 1ns/100ps
module guard_assertions
   import guard_pkg::*;
#(
   parameter logic [15:0] BOOT_START = 16'h7000
)
(
   input wire logic CLK_SYS, // clock
   input wire logic ARST_N, // reset, active low
   input wire logic WB_CYC_I, // cycle
   input wire logic WB_STB_I, // strobe
   input wire logic WB_WE_I, // write enable
   input wire logic [7:0] WB_ADR_I, // address
   input wire logic [31:0] WB_DAT_I, // write data
   input wire logic FUSE_LOAD, // fuse load pulse
   input wire logic FUSE_VALUE, // fuse value
   input wire logic WB_ACK_O, // acknowledge
   input wire logic [31:0] WB_DAT_O, // read data
   input wire logic FLASH_WE, // flash write strobe
   input wire logic [15:0] FLASH_WADDR, // latched write address
   input wire logic [15:0] RESET_VECTOR // reset fetch address
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!ARST_N);
   logic req_on;
   logic cmd_wr;
   logic wr_boot;
   assign req_on = WB_CYC_I && WB_STB_I;
   assign cmd_wr = req_on && WB_WE_I && WB_ADR_I == OFF_CMD;
   assign wr_boot = cmd_wr && WB_DAT_I[CMD_WRITE_POS] && WB_DAT_I[CMD_FROM_BOOT_POS];
   AST_ACK_NEXT: assert property (req_on && !WB_ACK_O |=> WB_ACK_O)
      else $error("no ack one cycle after request");
   AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held past one cycle");
   AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(req_on))
      else $error("ack without request");
   AST_WE_CAUSE: assert property (FLASH_WE |-> WB_ACK_O && $past(wr_boot))
      else $error("flash write without boot-issued write command");
   AST_WADDR_LATCH: assert property (!$stable(FLASH_WADDR) |-> $past(cmd_wr))
      else $error("write address moved outside a command");
   AST_FUSE_VEC: assert property (FUSE_LOAD |-> ##2
      RESET_VECTOR == ($past(FUSE_VALUE, 2) ? APP_RESET_ADDR : BOOT_START))
      else $error("reset vector does not follow fuse");
   AST_FUSE_HOLD: assert property (!FUSE_LOAD && !$past(FUSE_LOAD) |=> $stable(RESET_VECTOR))
      else $error("reset vector changed without fuse load");
   AST_DAT_HOLD: assert property (!WB_ACK_O |-> $stable(WB_DAT_O))
      else $error("read data changed without ack");
endmodule
bind boot_section_access_guard guard_assertions #(.BOOT_START(BOOT_START)) guard_assertions_inst
(
   .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .FUSE_LOAD(FUSE_LOAD),
   .FUSE_VALUE(FUSE_VALUE), .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .FLASH_WE(FLASH_WE),
   .FLASH_WADDR(FLASH_WADDR), .RESET_VECTOR(RESET_VECTOR)
);

// >>> flash_model.sv
/*
 flash array stand-in answering a word for any word address.
 assumes the guard samples the word a cycle after its read request.
*/
`timescale 1ns/100ps
module flash_model
(
   input wire logic [15:0] addr, // word address from the guard
   output logic [15:0] data // word at that address
);
   // pattern differs per byte so a wrong byte select shows
   assign data = {addr[7:0] ^ 8'h5A, addr[15:8]};
endmodule

// >>> tb_boot_section_access_guard.sv
/*
 self-checking bench: lock fields, pointer latching, reads, interrupt mask, fuse.
 assumes guard_pkg, flash_model and the bound checker are compiled first.
*/
`timescale 1ns/100ps
module tb_boot_section_access_guard
   import guard_pkg::*;
;
   localparam logic [15:0] BOOT = 16'h7000;
   logic clk = 0, arst_n = 0, erase = 0, fload = 0, fval = 1, fwe, irq, we_seen;
   wb_req_type req = '0;
   wire wb_rsp_type rsp;
   logic [15:0] waddr, raddr, frd, rvec;
   logic [31:0] rd;
   int n_mismatch = 0, checks_done = 0;
   always #10 clk = ~clk;
   boot_section_access_guard #(.BOOT_START(BOOT)) boot_section_access_guard_inst
   (
      .CLK_SYS(clk), .ARST_N(arst_n), .WB_CYC_I(req.cyc), .WB_STB_I(req.stb),
      .WB_WE_I(req.we), .WB_SEL_I(req.sel), .WB_ADR_I(req.adr), .WB_DAT_I(req.dat),
      .CHIP_ERASE(erase), .FUSE_LOAD(fload), .FUSE_VALUE(fval), .FLASH_RDATA(frd),
      .WB_ACK_O(rsp.ack), .WB_DAT_O(rsp.dat), .FLASH_WE(fwe), .FLASH_WADDR(waddr),
      .FLASH_RADDR(raddr), .IRQ_MASK(irq), .RESET_VECTOR(rvec)
   );
   flash_model flash_model_inst (.addr(raddr), .data(frd));
   task automatic results();
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
      int t;
      t = 0;
      req <= '{1'b1, 1'b1, w, 4'hF, a, d};
      do
         @(posedge clk);
      while (rsp.ack !== 1'b1 && ++t < 50);
      if (t == 50)
      begin
         n_mismatch++;
         results();
      end
      rd = rsp.dat;
      we_seen = fwe;
      req <= '0;
      @(posedge clk);
   endtask
   initial
   begin
      logic [3:0] l;
      logic [15:0] p, w;
      logic bt, fb, iv, rok;
      void'($urandom(74));
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      wb(0, OFF_LOCK, 0);
      chk("lock", 32'(LOCK_RESET), rd);
      wb(1, OFF_FUSE, 0);
      wb(0, OFF_FUSE, 0);
      chk("fuse", 1, rd[0]);
      chk("vector", APP_RESET_ADDR, rvec);
      wb(0, 8'h40, 32'h0000_FFFF);
      chk("unmapped", 0, rd);
      for (int i = 0; i < 64; i++)
      begin
         l = i[3:0];
         bt = i[4];
         fb = i[5];
         // sections meet at byte 2*BOOT; hit both sides of it now and then
         p = (i % 5 == 0) ? {BOOT[14:0], 1'b0} - 16'(!bt) : bt ? {3'b111, 13'($urandom)}
            : 16'($urandom % 32'h0000_E000);
         iv = p[3];
         erase <= 1'b1;
         @(posedge clk);
         erase <= 1'b0;
         wb(1, OFF_LOCK, 32'(l));
         wb(1, OFF_LOCK, 32'h0000_000F);
         wb(0, OFF_LOCK, 0);
         chk("lock", 32'(l), rd);
         wb(1, OFF_POINTER, 32'(p));
         wb(1, OFF_CMD, {27'h0, iv, fb, 3'b001});
         chk("flash_we", fb && (bt ? l[2] : l[0]), we_seen);
         wb(0, OFF_STATUS, 0);
         chk("refused", 32'(!fb), 32'(rd[3]));
         if (fb)
         begin
            chk("rejected", 32'(!(bt ? l[2] : l[0])), 32'(rd[0]));
            chk("done", 1, 32'(rd[2]));
         end
         wb(1, OFF_POINTER, 32'(~p));
         if (fb)
         begin
            chk("waddr", p >> 1, waddr);
            wb(0, OFF_WADDR, 0);
            chk("page", 32'(p[15:8]), 32'(rd[15:7]));
            chk("word", 32'(p[7:1]), 32'(rd[6:0]));
         end
         chk("irq", fb ? !iv && !l[3] : iv && !l[1], irq);
         // same page again before the next command
         wb(1, OFF_POINTER, 32'(p));
         wb(1, OFF_CMD, {27'h0, iv, fb, 3'b010});
         wb(0, OFF_RDATA, 0);
         w = {p[8:1] ^ 8'h5A, 1'b0, p[15:9]};
         rok = bt == fb || (bt ? l[3] : l[1]);
         if (rok)
            chk("rbyte", p[0] ? w[15:8] : w[7:0], rd[7:0]);
         else
            chk("rbyte", 0, rd[7:0]);
         wb(0, OFF_STATUS, 0);
         chk("read_rejected", 32'(!rok), 32'(rd[1]));
      end
      fval <= 1'b0;
      fload <= 1'b1;
      @(posedge clk);
      fload <= 1'b0;
      repeat (3) @(posedge clk);
      chk("vector", BOOT, rvec);
      wb(0, OFF_FUSE, 0);
      chk("fuse", 0, rd[0]);
      results();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      results();
   end
endmodule
